// ### src/vsm_cfg.sv
// Configuration registers and answer path for the two inbound map decoders.
// Assumes a one-clock register port and requests from same-clock logic.
//
// Functional notes
// - Decoder two value becomes offset under adder.
// - Post writes only while decoder post bit set.
// - Adder bit selects addition over bit replacement.
// - Snoop bits stored but without any effect.
// - Enable only with one bit per group.
// - Data cycles answered only with data bit.
// - Program cycles answered only with program bit.
// - Block cycles answered only with block bit.
// - D64 cycles answered only with D64 bit.
// - A24 cycles answered only with A24 bit.
// - A32 cycles answered only with A32 bit.
// - User cycles answered only with user bit.
// - Supervisory cycles answered only with supervisory bit.
// - One control word, decoder two upper half.
// - Replacement takes window bit where select set.
// - Adder sums offset with upper address bits.
// - A24 cycles zero top byte before compare.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vsm_cfg (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Register port
    input  wire logic [7:0]            bus_addr,
    input  wire logic [31:0]           bus_wdata,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    output logic      [31:0]           bus_rdata,
    // Inbound request
    input  wire logic                  vme_valid,
    input  wire logic [31:0]           vme_addr,
    input  wire vsm_pkg::vsm_cyc_t     vme_cyc,
    input  wire logic                  vme_a32,
    input  wire logic                  vme_super,
    input  wire logic                  vme_write,
    // Answer, one cycle after the request
    output logic                       resp_valid,
    output logic                       resp_claim,
    output logic                       resp_sel_two,
    output logic                       resp_post,
    output logic      [31:0]           resp_laddr
);
    import vsm_pkg::*;

    // Register file
    logic [31:0] range_one_reg, range_one_next;  // End hi, start lo
    logic [31:0] range_two_reg, range_two_next;
    logic [31:0] xlat_one_reg,  xlat_one_next;   // Address hi, select lo
    logic [31:0] xlat_two_reg,  xlat_two_next;   // Offset hi, select lo
    logic [31:0] ctrl_reg,      ctrl_next;       // Both decoders' controls
    logic [31:0] rdata_reg,     rdata_next;      // Read data, one cycle late
    // Answer path
    logic        valid_reg,  valid_next;
    logic        claim_reg,  claim_next;
    logic        sel_two_reg, sel_two_next;
    logic        post_reg,   post_next;
    logic [31:0] laddr_reg,  laddr_next;
    // Status snapshot of the last request
    logic [2:0]  last_reg,   last_next;

    vsm_dec_if dif_one ();
    vsm_dec_if dif_two ();

    // Register writes and read mux
    always_comb begin
        range_one_next = range_one_reg;
        range_two_next = range_two_reg;
        xlat_one_next  = xlat_one_reg;
        xlat_two_next  = xlat_two_reg;
        ctrl_next      = ctrl_reg;
        rdata_next     = rdata_reg;
        if (bus_wr) begin
            unique case (bus_addr)
                VSM_OFS_RANGE_ONE: range_one_next = bus_wdata;
                VSM_OFS_RANGE_TWO: range_two_next = bus_wdata;
                // Select values are taken as written
                VSM_OFS_XLAT_ONE:  xlat_one_next  = bus_wdata;
                VSM_OFS_XLAT_TWO:  xlat_two_next  = bus_wdata;
                // Snoop bits are kept even though nothing reads them
                VSM_OFS_CTRL:      ctrl_next = bus_wdata & VSM_CTRL_MASK;
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        if (bus_rd) begin
            unique case (bus_addr)
                VSM_OFS_RANGE_ONE: rdata_next = range_one_reg;
                VSM_OFS_RANGE_TWO: rdata_next = range_two_reg;
                VSM_OFS_XLAT_ONE:  rdata_next = xlat_one_reg;
                VSM_OFS_XLAT_TWO:  rdata_next = xlat_two_reg;
                VSM_OFS_CTRL:      rdata_next = ctrl_reg;
                VSM_OFS_STATUS:    rdata_next = {29'h0000_0000, last_reg};
                default:           rdata_next = 32'h0000_0000;
            endcase
        end else begin
            // Data stand only in the cycle after the strobe
            rdata_next = 32'h0000_0000;
        end
    end

    // Register file storage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            range_one_reg <= VSM_RST_WORD;
            range_two_reg <= VSM_RST_WORD;
            xlat_one_reg  <= VSM_RST_WORD;
            xlat_two_reg  <= VSM_RST_WORD;
            ctrl_reg      <= VSM_RST_WORD;
            rdata_reg     <= VSM_RST_WORD;
        end else begin
            range_one_reg <= range_one_next;
            range_two_reg <= range_two_next;
            xlat_one_reg  <= xlat_one_next;
            xlat_two_reg  <= xlat_two_next;
            ctrl_reg      <= ctrl_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Decoder one wiring, lower control half
    always_comb begin
        dif_one.start_hi = range_one_reg[VSM_HALF_W-1:0];
        dif_one.end_hi   = range_one_reg[31:VSM_HALF_W];
        dif_one.xaddr    = xlat_one_reg[31:VSM_HALF_W];
        dif_one.xsel     = xlat_one_reg[VSM_HALF_W-1:0];
        dif_one.am_sel   = ctrl_reg[VSM_POS_AM_ONE +: 8];
        dif_one.sum_en   = ctrl_reg[VSM_POS_SUM_ONE];
        dif_one.post_en  = ctrl_reg[VSM_POS_POST_ONE];
        dif_one.vaddr    = vme_addr;
        dif_one.cyc      = vme_cyc;
        dif_one.a32      = vme_a32;
        dif_one.supv     = vme_super;
        dif_one.write    = vme_write;
    end

    // Decoder two wiring, upper control half
    always_comb begin
        dif_two.start_hi = range_two_reg[VSM_HALF_W-1:0];
        dif_two.end_hi   = range_two_reg[31:VSM_HALF_W];
        dif_two.xaddr    = xlat_two_reg[31:VSM_HALF_W];
        dif_two.xsel     = xlat_two_reg[VSM_HALF_W-1:0];
        dif_two.am_sel   = ctrl_reg[VSM_POS_AM_TWO +: 8];
        dif_two.sum_en   = ctrl_reg[VSM_POS_SUM_TWO];
        dif_two.post_en  = ctrl_reg[VSM_POS_POST_TWO];
        dif_two.vaddr    = vme_addr;
        dif_two.cyc      = vme_cyc;
        dif_two.a32      = vme_a32;
        dif_two.supv     = vme_super;
        dif_two.write    = vme_write;
    end

    vsm_dec u_dec_one (
        .d (dif_one.dec)
    );

    vsm_dec u_dec_two (
        .d (dif_two.dec)
    );

    // Answer selection; overlapping segments resolve to decoder one
    always_comb begin
        valid_next   = vme_valid;
        claim_next   = 1'b0;
        sel_two_next = 1'b0;
        post_next    = 1'b0;
        laddr_next   = laddr_reg;
        last_next    = last_reg;
        if (vme_valid) begin
            if (dif_one.hit) begin
                claim_next = 1'b1;
                post_next  = dif_one.post;
                laddr_next = dif_one.laddr;
            end else if (dif_two.hit) begin
                claim_next   = 1'b1;
                sel_two_next = 1'b1;
                post_next    = dif_two.post;
                laddr_next   = dif_two.laddr;
            end else begin
                // Not ours: address output holds its last value
            end
            last_next = {dif_one.post | dif_two.post, dif_two.hit, dif_one.hit};
        end
    end

    // Answer registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            valid_reg   <= 1'b0;
            claim_reg   <= 1'b0;
            sel_two_reg <= 1'b0;
            post_reg    <= 1'b0;
            laddr_reg   <= VSM_RST_WORD;
            last_reg    <= 3'h0;
        end else begin
            valid_reg   <= valid_next;
            claim_reg   <= claim_next;
            sel_two_reg <= sel_two_next;
            post_reg    <= post_next;
            laddr_reg   <= laddr_next;
            last_reg    <= last_next;
        end
    end

    assign bus_rdata    = rdata_reg;
    assign resp_valid   = valid_reg;
    assign resp_claim   = claim_reg;
    assign resp_sel_two = sel_two_reg;
    assign resp_post    = post_reg;
    assign resp_laddr   = laddr_reg;

    // Checks on the answer and register behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_ctrl_rd;
        bus_rd && bus_addr == VSM_OFS_CTRL;
    endsequence

    sequence s_req_one;
        vme_valid && dif_one.hit;
    endsequence

    // Decoder two only wins when decoder one stays quiet
    sequence s_req_two;
        vme_valid && dif_two.hit && !dif_one.hit;
    endsequence

    AST_CTRL_READBACK: assert property (
        s_ctrl_rd |=> bus_rdata == ($past(ctrl_reg) & VSM_CTRL_MASK))
        else $error("control word read back wrong");

    AST_SNOOP_STORED: assert property (
        bus_wr && bus_addr == VSM_OFS_CTRL ##1 !bus_wr ##1 s_ctrl_rd
        |=> bus_rdata[VSM_POS_SNOOP_TWO] == $past(bus_wdata[VSM_POS_SNOOP_TWO], 3))
        else $error("snoop bit not stored");

    AST_GROUP_GATE: assert property (
        vme_valid && !(|ctrl_reg[VSM_AM_A32:VSM_AM_A24]) && !dif_two.hit
        |=> !resp_claim)
        else $error("decoder one claimed without width group");

    AST_DATA_GATE: assert property (
        vme_valid && vme_cyc == VSM_CYC_DATA && !ctrl_reg[VSM_AM_DATA]
        |-> !dif_one.hit)
        else $error("data cycle claimed without data bit");

    AST_PRIV_GATE: assert property (
        vme_valid && vme_super && !ctrl_reg[VSM_POS_AM_TWO + VSM_AM_SUPER]
        |-> !dif_two.hit)
        else $error("supervisory cycle claimed without its bit");

    AST_WIDTH_GATE: assert property (
        vme_valid && vme_a32 && !ctrl_reg[VSM_AM_A32] |-> !dif_one.hit)
        else $error("extended cycle claimed without its bit");

    AST_CLAIM_ONE: assert property (
        s_req_one |=> resp_valid && resp_claim && !resp_sel_two)
        else $error("decoder one hit not answered");

    AST_POST_GATE: assert property (
        resp_post |-> resp_claim && $past(vme_write)
        && (resp_sel_two ? $past(ctrl_reg[VSM_POS_POST_TWO])
                         : $past(ctrl_reg[VSM_POS_POST_ONE])))
        else $error("write posted without post enable");

    AST_SUM_XLAT: assert property (
        s_req_one and (ctrl_reg[VSM_POS_SUM_ONE] && vme_a32)
        |=> resp_laddr[31:16] == 16'($past(vme_addr[31:16]) + $past(xlat_one_reg[31:16])))
        else $error("adder translation wrong");

    AST_A24_ZERO: assert property (
        s_req_one and (!vme_a32) |-> range_one_reg[15:0] <= 16'h00FF)
        else $error("short cycle matched above top byte zero");

    // Per-bit gates on decoder one; decoder two shares the same logic
    AST_PROG_GATE: assert property (
        vme_valid && vme_cyc == VSM_CYC_PROG && !ctrl_reg[VSM_AM_PROG] |-> !dif_one.hit)
        else $error("program cycle claimed without program bit");

    AST_BLOCK_GATE: assert property (
        vme_valid && vme_cyc == VSM_CYC_BLOCK && !ctrl_reg[VSM_AM_BLOCK] |-> !dif_one.hit)
        else $error("block cycle claimed without block bit");

    AST_D64_GATE: assert property (
        vme_valid && vme_cyc == VSM_CYC_D64 && !ctrl_reg[VSM_AM_D64] |-> !dif_one.hit)
        else $error("D64 cycle claimed without D64 bit");

    AST_A24_GATE: assert property (
        vme_valid && !vme_a32 && !ctrl_reg[VSM_AM_A24] |-> !dif_one.hit)
        else $error("standard cycle claimed without its bit");

    AST_USER_GATE: assert property (
        vme_valid && !vme_super && !ctrl_reg[VSM_AM_USER] |-> !dif_one.hit)
        else $error("user cycle claimed without user bit");

    AST_CLAIM_TWO: assert property (
        s_req_two |=> resp_valid && resp_claim && resp_sel_two)
        else $error("decoder two hit not answered");

    // Offset wraps at 64K segments, so the carry is dropped on purpose
    AST_SUM_TWO: assert property (
        s_req_two and (ctrl_reg[VSM_POS_SUM_TWO] && vme_a32)
        |=> resp_laddr[31:16] == 16'($past(vme_addr[31:16]) + $past(xlat_two_reg[31:16])))
        else $error("decoder two offset translation wrong");
endmodule : vsm_cfg
`default_nettype wire

// ### src/vsm_pkg.sv
// Constants shared by the inbound map decoder configuration block.
// Assumes a byte-addressed register port with 32-bit data words.
package vsm_pkg;
    // Register byte offsets
    localparam logic [7:0]  VSM_OFS_RANGE_ONE = 8'h00; // End hi / start lo
    localparam logic [7:0]  VSM_OFS_RANGE_TWO = 8'h04;
    localparam logic [7:0]  VSM_OFS_XLAT_ONE  = 8'h08; // Addr hi / select lo
    localparam logic [7:0]  VSM_OFS_XLAT_TWO  = 8'h0C; // Offset hi / select lo
    localparam logic [7:0]  VSM_OFS_CTRL      = 8'h10; // Both decoders' controls
    localparam logic [7:0]  VSM_OFS_STATUS    = 8'h40; // Last answer seen
    // Field positions in the control word
    localparam int          VSM_HALF_W        = 16;
    localparam int          VSM_POS_POST_TWO  = 24;
    localparam int          VSM_POS_SNOOP_TWO = 26;
    localparam int          VSM_POS_SUM_TWO   = 27;
    localparam int          VSM_POS_AM_TWO    = 16;
    localparam int          VSM_POS_POST_ONE  = 8;
    localparam int          VSM_POS_SNOOP_ONE = 10;
    localparam int          VSM_POS_SUM_ONE   = 11;
    localparam int          VSM_POS_AM_ONE    = 0;
    // Modifier select byte layout
    localparam int          VSM_AM_DATA       = 0;
    localparam int          VSM_AM_PROG       = 1;
    localparam int          VSM_AM_BLOCK      = 2;
    localparam int          VSM_AM_D64        = 3;
    localparam int          VSM_AM_A24        = 4;
    localparam int          VSM_AM_A32        = 5;
    localparam int          VSM_AM_USER       = 6;
    localparam int          VSM_AM_SUPER      = 7;
    // Implemented control bits; the rest read as zero
    localparam logic [31:0] VSM_CTRL_MASK     = 32'h0DFF_0DFF;
    // Reset values
    localparam logic [31:0] VSM_RST_WORD      = 32'h0000_0000;
    // Cycle type carried with an inbound request
    typedef enum logic [1:0] {
        VSM_CYC_DATA  = 2'h0,
        VSM_CYC_PROG  = 2'h1,
        VSM_CYC_BLOCK = 2'h2,
        VSM_CYC_D64   = 2'h3
    } vsm_cyc_t;
endpackage : vsm_pkg

// ### src/vsm_dec_if.sv
// Carrier between the configuration top and one map decoder.
// Assumes vsm_pkg is compiled first.
`timescale 1ns/10ps
`default_nettype none
interface vsm_dec_if;
    import vsm_pkg::*;
    logic [15:0] start_hi;  // Segment start, address bits 31..16
    logic [15:0] end_hi;    // Segment end, address bits 31..16
    logic [15:0] xaddr;     // Translation address or offset
    logic [15:0] xsel;      // Translation select mask
    logic [7:0]  am_sel;    // Modifier select byte
    logic        sum_en;    // Adder translation
    logic        post_en;   // Write posting
    logic [31:0] vaddr;     // Inbound address
    vsm_cyc_t    cyc;       // Inbound cycle type
    logic        a32;       // Extended address cycle
    logic        supv;      // Supervisory cycle
    logic        write;     // Write cycle
    logic        hit;       // Decoder claims the cycle
    logic        post;      // Claimed write may be posted
    logic [31:0] laddr;     // Translated local address
    modport cfg (output start_hi, end_hi, xaddr, xsel, am_sel, sum_en, post_en,
                 vaddr, cyc, a32, supv, write, input hit, post, laddr);
    modport dec (input start_hi, end_hi, xaddr, xsel, am_sel, sum_en, post_en,
                 vaddr, cyc, a32, supv, write, output hit, post, laddr);
endinterface : vsm_dec_if
`default_nettype wire

// ### src/vsm_dec.sv
// One inbound map decoder: modifier match, range compare, translation.
// Assumes a single clock domain; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module vsm_dec (
    // Configuration and request in, answer out
    vsm_dec_if.dec d
);
    import vsm_pkg::*;

    logic        enabled;   // One bit set in every group
    logic        type_ok;   // Cycle type selected
    logic        width_ok;  // Address width selected
    logic        priv_ok;   // Privilege selected
    logic [15:0] cmp_hi;    // Compared upper address
    logic        in_range;  // Inside start..end
    logic [15:0] sum_hi;    // Adder result
    logic [15:0] rep_hi;    // Replacement result

    // Group gating and per-bit cycle matching
    always_comb begin
        enabled = (|d.am_sel[VSM_AM_D64:VSM_AM_DATA])
                & (|d.am_sel[VSM_AM_A32:VSM_AM_A24])
                & (|d.am_sel[VSM_AM_SUPER:VSM_AM_USER]);
        unique case (d.cyc)
            VSM_CYC_DATA:  type_ok = d.am_sel[VSM_AM_DATA];
            VSM_CYC_PROG:  type_ok = d.am_sel[VSM_AM_PROG];
            VSM_CYC_BLOCK: type_ok = d.am_sel[VSM_AM_BLOCK];
            VSM_CYC_D64:   type_ok = d.am_sel[VSM_AM_D64];
        endcase
        // Standard or extended width
        width_ok = d.a32 ? d.am_sel[VSM_AM_A32] : d.am_sel[VSM_AM_A24];
        // Privilege
        priv_ok  = d.supv ? d.am_sel[VSM_AM_SUPER] : d.am_sel[VSM_AM_USER];
    end

    // Range compare and translation
    always_comb begin
        // Short cycles drop the top byte before compare
        cmp_hi   = d.a32 ? d.vaddr[31:16] : {8'h00, d.vaddr[23:16]};
        in_range = (cmp_hi >= d.start_hi) && (cmp_hi <= d.end_hi);
        // Adder wraps at 4GB; carry out is dropped
        sum_hi   = 16'(cmp_hi + d.xaddr);
        // Bitwise pick between window and bus address
        rep_hi   = (d.xaddr & d.xsel) | (cmp_hi & ~d.xsel);
        d.laddr  = {(d.sum_en ? sum_hi : rep_hi), d.vaddr[15:0]};
        d.hit    = enabled & type_ok & width_ok & priv_ok & in_range;
        d.post   = d.hit & d.write & d.post_en;
    end
endmodule : vsm_dec
`default_nettype wire

// ### test/vsm_master_model.sv
// Behavioural off-board master that issues one inbound request at a time.
// Assumes the answer stands in the single cycle after the request edge.
`timescale 1ns/10ps
`default_nettype none
module vsm_master_model (
    // Clock
    input  wire logic              mclk,
    // Request towards the block
    output var  logic              vme_valid,
    output var  logic [31:0]       vme_addr,
    output var  vsm_pkg::vsm_cyc_t vme_cyc,
    output var  logic              vme_a32,
    output var  logic              vme_super,
    output var  logic              vme_write,
    // Answer from the block
    input  wire logic              resp_valid,
    input  wire logic              resp_claim,
    input  wire logic              resp_sel_two,
    input  wire logic              resp_post,
    input  wire logic [31:0]       resp_laddr
);
    import vsm_pkg::*;

    // Idle at time zero
    initial begin
        vme_valid = 1'b0;
        vme_addr  = 32'h0000_0000;
        vme_cyc   = VSM_CYC_DATA;
        vme_a32   = 1'b0;
        vme_super = 1'b0;
        vme_write = 1'b0;
    end

    // One request pulse, then qualifiers flip so stale values never match
    task automatic issue(input logic [31:0] a, input vsm_cyc_t c, input logic w32,
                         input logic s, input logic w, output logic v, output logic cl,
                         output logic two, output logic po, output logic [31:0] la);
        @(posedge mclk);
        vme_valid <= 1'b1;
        vme_addr  <= a;
        vme_cyc   <= c;
        vme_a32   <= w32;
        vme_super <= s;
        vme_write <= w;
        @(posedge mclk);
        vme_valid <= 1'b0;
        vme_addr  <= ~a;
        vme_cyc   <= vsm_cyc_t'(~c);
        vme_a32   <= ~w32;
        vme_super <= ~s;
        vme_write <= ~w;
        // Answer is only valid in this one cycle
        #1;
        v   = resp_valid;
        cl  = resp_claim;
        two = resp_sel_two;
        po  = resp_post;
        la  = resp_laddr;
    endtask : issue
endmodule : vsm_master_model
`default_nettype wire

// ### test/vsm_cfg_tb_top.sv
// Self-checking bench for the inbound map decoder configuration block.
// Assumes vsm_pkg, vsm_dec_if, vsm_dec, vsm_cfg and the master model compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module vsm_cfg_tb_top;
    import vsm_pkg::*;
    logic              mclk, nrst;         // Clock and reset
    logic [7:0]        bus_addr;           // Register port
    logic [31:0]       bus_wdata, bus_rdata;
    logic              bus_wr, bus_rd;
    logic              vme_valid, vme_a32, vme_super, vme_write;
    logic [31:0]       vme_addr, resp_laddr;
    vsm_cyc_t          vme_cyc;
    logic              resp_valid, resp_claim, resp_sel_two, resp_post;
    int                mismatches  = 0;    // Failed comparisons
    int                check_count = 0;    // All comparisons

    vsm_cfg u_vsm_cfg (.mclk(mclk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .vme_valid(vme_valid),
        .vme_addr(vme_addr), .vme_cyc(vme_cyc), .vme_a32(vme_a32), .vme_super(vme_super),
        .vme_write(vme_write), .resp_valid(resp_valid), .resp_claim(resp_claim),
        .resp_sel_two(resp_sel_two), .resp_post(resp_post), .resp_laddr(resp_laddr));
    vsm_master_model u_vsm_master_model (.mclk(mclk), .vme_valid(vme_valid),
        .vme_addr(vme_addr), .vme_cyc(vme_cyc), .vme_a32(vme_a32), .vme_super(vme_super),
        .vme_write(vme_write), .resp_valid(resp_valid), .resp_claim(resp_claim),
        .resp_sel_two(resp_sel_two), .resp_post(resp_post), .resp_laddr(resp_laddr));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Verdict and end of run
    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge mclk);
        bus_wr    <= 1'b0;
    endtask : wr

    // Read strobe, data sampled in the following cycle only
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd   <= 1'b0;
        #1;
        `CHK(bus_rdata, exp)
    endtask : chk_rd

    // Inbound request through the master model, answer judged here
    task automatic req(input logic [31:0] a, input vsm_cyc_t c, input logic w32, input logic s,
                       input logic w, input logic ecl, input logic etwo, input logic epo,
                       input logic [31:0] ela);
        logic v, cl, two, po;
        logic [31:0] la;
        u_vsm_master_model.issue(a, c, w32, s, w, v, cl, two, po, la);
        `CHK(v, 1'b1)
        `CHK(cl, ecl)
        if (ecl) begin
            `CHK(two, etwo)
            `CHK(po, epo)
            `CHK(la, ela)
        end
    endtask : req

    // Cleared registers leave both decoders deaf
    task automatic t_reset();
        chk_rd(VSM_OFS_CTRL, 32'h0000_0000);
        chk_rd(VSM_OFS_XLAT_ONE, 32'h0000_0000);
        chk_rd(VSM_OFS_XLAT_TWO, 32'h0000_0000);
        req(32'h0000_0000, VSM_CYC_DATA, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    endtask : t_reset

    // Packing of the control word, storage of select values, unmapped place
    task automatic t_regs();
        wr(VSM_OFS_CTRL, 32'hFFFF_FFFF);
        chk_rd(VSM_OFS_CTRL, 32'h0DFF_0DFF);
        wr(VSM_OFS_XLAT_TWO, 32'h1234_FFFE);
        chk_rd(VSM_OFS_XLAT_TWO, 32'h1234_FFFE);
        wr(VSM_OFS_XLAT_ONE, 32'hABCD_8000);
        chk_rd(VSM_OFS_XLAT_ONE, 32'hABCD_8000);
        wr(8'h20, 32'hFFFF_FFFF);
        chk_rd(8'h20, 32'h0000_0000);
        wr(VSM_OFS_CTRL, 32'h0000_0000);
    endtask : t_regs

    // Each modifier bit gates its own cycle kind; an empty group disables
    task automatic t_groups();
        logic [31:0] a, la;
        logic        w32, s;
        vsm_cyc_t    c;
        wr(VSM_OFS_RANGE_ONE, 32'hFFFF_0000);
        wr(VSM_OFS_XLAT_ONE, 32'h0000_0000);
        for (int b = 0; b < 8; b++) begin
            c   = (b < 4) ? vsm_cyc_t'(b[1:0]) : VSM_CYC_DATA;
            w32 = (b != 4);
            s   = (b != 6);
            a   = 32'h1234_5678;
            la  = w32 ? a : (a & 32'h00FF_FFFF);
            wr(VSM_OFS_CTRL, {24'h00_0000, 8'hFF & ~(8'h01 << b)});
            req(a, c, w32, s, 1'b0, 1'b0, 1'b0, 1'b0, la);
            wr(VSM_OFS_CTRL, 32'h0000_00FF);
            req(a, c, w32, s, 1'b0, 1'b1, 1'b0, 1'b0, la);
        end
        wr(VSM_OFS_CTRL, 32'h0000_003F);
        req(32'h1234_5678, VSM_CYC_DATA, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    endtask : t_groups

    // Replacement, inclusive bounds, A24 zeroing, posting on decoder one
    task automatic t_xlat();
        wr(VSM_OFS_RANGE_ONE, 32'h001F_0010);
        wr(VSM_OFS_XLAT_ONE, 32'hABCD_FFF0);
        wr(VSM_OFS_CTRL, 32'h0000_04FF);
        req(32'h0012_3456, VSM_CYC_DATA, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 32'hABC2_3456);
        req(32'h0010_0000, VSM_CYC_PROG, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 32'hABC0_0000);
        req(32'h001F_FFFF, VSM_CYC_BLOCK, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 32'hABCF_FFFF);
        req(32'h0020_0000, VSM_CYC_DATA, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        req(32'h000F_FFFF, VSM_CYC_DATA, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        req(32'hFF15_0000, VSM_CYC_DATA, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 32'hABC5_0000);
        wr(VSM_OFS_CTRL, 32'h0000_01FF);
        req(32'h0011_0000, VSM_CYC_D64, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 32'hABC1_0000);
        req(32'h0011_0000, VSM_CYC_D64, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 32'hABC1_0000);
    endtask : t_xlat

    // Adder on both decoders, modulo wrap, snoop bit without effect
    task automatic t_adder();
        wr(VSM_OFS_CTRL, 32'h0000_08FF);
        req(32'h0012_3456, VSM_CYC_DATA, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 32'hABDF_3456);
        wr(VSM_OFS_CTRL, 32'h0DFF_0000);
        wr(VSM_OFS_RANGE_TWO, 32'h01FF_0010);
        wr(VSM_OFS_XLAT_TWO, 32'hFFF8_0000);
        req(32'h0123_4567, VSM_CYC_DATA, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 32'h011B_4567);
        req(32'hAB15_1234, VSM_CYC_DATA, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 32'h000D_1234);
        wr(VSM_OFS_CTRL, 32'h0CFF_0000);
        req(32'h0123_4567, VSM_CYC_DATA, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 32'h011B_4567);
        wr(VSM_OFS_CTRL, 32'h04FF_0000);
        req(32'h0123_4567, VSM_CYC_DATA, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0123_4567);
        chk_rd(VSM_OFS_STATUS, 32'h0000_0002);
    endtask : t_adder

    // Main sequence
    initial begin
        nrst      = 1'b0;
        bus_addr  = 8'h00;
        bus_wdata = 32'h0000_0000;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_groups();
        t_xlat();
        t_adder();
        wrap_up();
    end

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        wrap_up();
    end
endmodule : vsm_cfg_tb_top
`undef CHK
`default_nettype wire
